// ===== ibt_evt_sync.sv
// toggle-based crossing of a vector of one-cycle events between two clocks
// assumes each event bit pulses no faster than the far side can follow
`timescale 1ns/1ns
module ibt_evt_sync #(
  parameter int W = 4
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic [W-1:0] src_pulse,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic      [W-1:0] dst_pulse
);

  logic [W-1:0] tog_r;
  logic [W-1:0] tog_nxt;
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_comb begin
    tog_nxt = tog_r ^ src_pulse;
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      tog_r <= '0;
    end else begin
      tog_r <= tog_nxt;
    end
  end

  // s1 feeds only s2; the edge is taken between s2 and s3
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= tog_r;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_comb begin
    dst_pulse = s2_r ^ s3_r;
  end

endmodule

// ===== ibt_master_tx.sv
// two-wire master byte transmitter: software side on SYS_CLK, bus side on LINK_CLK
// assumes open-drain pads resolved outside; RST_N is synchronous to SYS_CLK
//
// Function
// [R1] buffer write sets full flag, starts transfer
// [R2] sda changes only while scl low
// [R3] scl low one baud interval per bit
// [R4] scl high one interval, sda held stable
// [R5] eighth fall clears full flag, frees sda
// [R6] ninth clock stores ack: 0 ack, 1 nack
// [R7] after ninth clock irq set, clock suspended
// [R8] address: seven bits then direction bit
// [R9] after address ack scl low, sda floating
// [R10] write while busy sets collision, discarded
// [R11] software clears collision flag itself
// [R12] start request, irq on start completion
// [R13] software clears irq after each event
// [R14] start hold time before next operation
// [R15] stop or restart request, irq on completion
// [R16] slave acks address and good data
// [R17] bytes go out msb first
// [R18] baud interval from programmable reload count
`timescale 1ns/1ns
module ibt_master_tx #(
  parameter int BAUD_W = ibt_pkg::BAUD_W_DEF
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              SHIFT_BUFFER_WR,
  input  wire logic [7:0]        SHIFT_BUFFER_DATA,
  input  wire logic              START_REQ,
  input  wire logic              STOP_REQ,
  input  wire logic              RSTART_REQ,
  input  wire logic              IRQ_CLR,
  input  wire logic              WRITE_COLLISION_FLAG_CLR,
  input  wire logic [BAUD_W-1:0] BAUD_RELOAD,
  output logic                   BUFFER_FULL_FLAG,
  output logic                   PORT_IRQ_FLAG,
  output logic                   ACK_RECEIVED_STATUS,
  output logic                   WRITE_COLLISION_FLAG,
  output logic                   START_REQUEST_BIT,
  output logic                   STOP_REQUEST_BIT,
  output logic                   REPEATED_START_REQUEST_BIT,
  output logic                   BUSY,
  input  wire logic              LINK_CLK,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE,
  output logic                   SCL_O,
  output logic                   SCL_OE
);

  // ---------------- system side
  logic [ibt_pkg::GO_W-1:0] go_r;
  logic [ibt_pkg::GO_W-1:0] go_nxt;
  logic [ibt_pkg::DN_W-1:0] dn_sys;
  logic [7:0]               txbuf_r;
  logic [7:0]               txbuf_nxt;
  logic                     busy_r;
  logic                     busy_nxt;
  logic                     bf_r;
  logic                     bf_nxt;
  logic                     irq_r;
  logic                     irq_nxt;
  logic                     ack_r;
  logic                     ack_nxt;
  logic                     write_collision_flag_r;
  logic                     write_collision_flag_nxt;
  logic                     sen_r;
  logic                     sen_nxt;
  logic                     pen_r;
  logic                     pen_nxt;
  logic                     repeated_start_request_bit_r;
  logic                     repeated_start_request_bit_nxt;

  // ---------------- link side
  logic                     lrst_s1_r;
  logic                     lrst_n_r;
  logic [ibt_pkg::GO_W-1:0] go_lnk;
  logic [ibt_pkg::DN_W-1:0] dn_r;
  logic [ibt_pkg::DN_W-1:0] dn_nxt;
  logic                     sda_s1_r;
  logic                     sda_s2_r;
  logic [BAUD_W-1:0]        rl_s1_r;
  logic [BAUD_W-1:0]        rl_s2_r;
  ibt_pkg::ibt_state_e      st_r;
  ibt_pkg::ibt_state_e      st_nxt;
  logic [BAUD_W-1:0]        cnt_r;
  logic [BAUD_W-1:0]        cnt_nxt;
  logic [7:0]               shreg_r;
  logic [7:0]               shreg_nxt;
  logic [3:0]               bitcnt_r;
  logic [3:0]               bitcnt_nxt;
  logic                     pend_r;
  logic                     pend_nxt;
  logic                     scl_oe_r;
  logic                     scl_oe_nxt;
  logic                     sda_oe_r;
  logic                     sda_oe_nxt;
  logic                     lack_r;
  logic                     lack_nxt;
  logic                     rs_r;
  logic                     rs_nxt;
  logic                     drive_lo_r;
  logic                     tick;

  always_comb begin
    go_nxt    = '0;
    txbuf_nxt = txbuf_r;
    busy_nxt  = busy_r;
    bf_nxt    = bf_r;
    irq_nxt   = irq_r;
    ack_nxt   = ack_r;
    write_collision_flag_nxt  = write_collision_flag_r;
    sen_nxt   = sen_r;
    pen_nxt   = pen_r;
    repeated_start_request_bit_nxt  = repeated_start_request_bit_r;
    // clears first so a same-cycle hardware set wins
    if (IRQ_CLR) begin
      irq_nxt = 1'b0;                                           // see [R13]
    end
    if (WRITE_COLLISION_FLAG_CLR) begin
      write_collision_flag_nxt = 1'b0;                                          // see [R11]
    end
    if (dn_sys[ibt_pkg::DN_BF_CLR]) begin
      bf_nxt = 1'b0;                                            // see [R5]
    end
    if (dn_sys[ibt_pkg::DN_BYTE]) begin
      ack_nxt  = lack_r;                                        // see [R6]
      irq_nxt  = 1'b1;                                          // see [R7]
      busy_nxt = 1'b0;
    end
    if (dn_sys[ibt_pkg::DN_START]) begin
      sen_nxt  = 1'b0;
      irq_nxt  = 1'b1;                                          // see [R12]
      busy_nxt = 1'b0;
    end
    if (dn_sys[ibt_pkg::DN_STOP]) begin
      pen_nxt  = 1'b0;
      irq_nxt  = 1'b1;                                          // see [R15]
      busy_nxt = 1'b0;
    end
    if (dn_sys[ibt_pkg::DN_RSTART]) begin
      repeated_start_request_bit_nxt = 1'b0;
      irq_nxt  = 1'b1;                                          // see [R15]
      busy_nxt = 1'b0;
    end
    // busy_r, not busy_nxt: a command in the completion cycle is still refused
    if (SHIFT_BUFFER_WR) begin
      if (busy_r) begin
        write_collision_flag_nxt = 1'b1;                                        // see [R10]
      end else begin
        txbuf_nxt             = SHIFT_BUFFER_DATA;
        bf_nxt                = 1'b1;                           // see [R1]
        busy_nxt              = 1'b1;
        go_nxt[ibt_pkg::GO_BYTE] = 1'b1;
      end
    end else if (!busy_r && START_REQ) begin
      sen_nxt                   = 1'b1;
      busy_nxt                  = 1'b1;
      go_nxt[ibt_pkg::GO_START] = 1'b1;                         // see [R12]
    end else if (!busy_r && STOP_REQ) begin
      pen_nxt                  = 1'b1;
      busy_nxt                 = 1'b1;
      go_nxt[ibt_pkg::GO_STOP] = 1'b1;                          // see [R15]
    end else if (!busy_r && RSTART_REQ) begin
      repeated_start_request_bit_nxt                   = 1'b1;
      busy_nxt                   = 1'b1;
      go_nxt[ibt_pkg::GO_RSTART] = 1'b1;                        // see [R15]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      go_r    <= '0;
      txbuf_r <= ibt_pkg::TXBUF_RST;
      busy_r  <= 1'b0;
      bf_r    <= 1'b0;
      irq_r   <= 1'b0;
      ack_r   <= 1'b0;
      write_collision_flag_r  <= 1'b0;
      sen_r   <= 1'b0;
      pen_r   <= 1'b0;
      repeated_start_request_bit_r  <= 1'b0;
    end else begin
      go_r    <= go_nxt;
      txbuf_r <= txbuf_nxt;
      busy_r  <= busy_nxt;
      bf_r    <= bf_nxt;
      irq_r   <= irq_nxt;
      ack_r   <= ack_nxt;
      write_collision_flag_r  <= write_collision_flag_nxt;
      sen_r   <= sen_nxt;
      pen_r   <= pen_nxt;
      repeated_start_request_bit_r  <= repeated_start_request_bit_nxt;
    end
  end

  ibt_evt_sync #(
    .W (ibt_pkg::GO_W)
  ) u_go_sync (
    .src_clk   (SYS_CLK),
    .src_rst_n (RST_N),
    .src_pulse (go_r),
    .dst_clk   (LINK_CLK),
    .dst_rst_n (lrst_n_r),
    .dst_pulse (go_lnk)
  );

  ibt_evt_sync #(
    .W (ibt_pkg::DN_W)
  ) u_dn_sync (
    .src_clk   (LINK_CLK),
    .src_rst_n (lrst_n_r),
    .src_pulse (dn_r),
    .dst_clk   (SYS_CLK),
    .dst_rst_n (RST_N),
    .dst_pulse (dn_sys)
  );

  // reset, sda and reload all cross into the link clock through two flops;
  // the reload is meant to be static while a transfer runs
  always_ff @(posedge LINK_CLK) begin
    lrst_s1_r <= RST_N;
    lrst_n_r  <= lrst_s1_r;
    sda_s1_r  <= SDA_I;
    sda_s2_r  <= sda_s1_r;
    rl_s1_r   <= BAUD_RELOAD;
    rl_s2_r   <= rl_s1_r;
  end

  // counter frozen at reload while idle, so the clock is suspended
  assign tick = (cnt_r == '0);

  always_comb begin
    st_nxt     = st_r;
    shreg_nxt  = shreg_r;
    bitcnt_nxt = bitcnt_r;
    pend_nxt   = pend_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    lack_nxt   = lack_r;
    rs_nxt     = rs_r;
    dn_nxt     = '0;
    if ((st_r == ibt_pkg::ST_IDLE) || tick) begin
      cnt_nxt = rl_s2_r;                                        // see [R18]
    end else begin
      cnt_nxt = cnt_r - 1'b1;
    end
    case (st_r)
      ibt_pkg::ST_IDLE: begin
        // idle keeps scl and sda as the last phase left them
        if (go_lnk[ibt_pkg::GO_BYTE]) begin
          // txbuf_r is stable: software side refuses writes while busy
          sda_oe_nxt = ~txbuf_r[7];                             // see [R17]
          shreg_nxt  = txbuf_r;
          bitcnt_nxt = ibt_pkg::BITCNT_RST;
          pend_nxt   = 1'b0;
          st_nxt     = ibt_pkg::ST_BIT_LOW;                     // see [R1]
        end else if (go_lnk[ibt_pkg::GO_START]) begin
          sda_oe_nxt = 1'b1;
          rs_nxt     = 1'b0;
          st_nxt     = ibt_pkg::ST_START_A;
        end else if (go_lnk[ibt_pkg::GO_STOP]) begin
          sda_oe_nxt = 1'b1;
          st_nxt     = ibt_pkg::ST_STOP_A;
        end else if (go_lnk[ibt_pkg::GO_RSTART]) begin
          sda_oe_nxt = 1'b0;
          rs_nxt     = 1'b1;
          st_nxt     = ibt_pkg::ST_RS_A;
        end
      end
      ibt_pkg::ST_START_A: begin
        if (tick) begin
          scl_oe_nxt = 1'b1;
          st_nxt     = ibt_pkg::ST_START_B;
        end
      end
      ibt_pkg::ST_START_B: begin
        // one full interval of start hold before completion
        if (tick) begin                                         // see [R14]
          if (rs_r) begin
            dn_nxt[ibt_pkg::DN_RSTART] = 1'b1;                  // see [R15]
          end else begin
            dn_nxt[ibt_pkg::DN_START] = 1'b1;                   // see [R12]
          end
          st_nxt = ibt_pkg::ST_IDLE;
        end
      end
      ibt_pkg::ST_BIT_LOW: begin
        // data moves one link cycle after the fall, giving hold time
        if (pend_r) begin
          sda_oe_nxt = ~shreg_r[7];                             // see [R2]
          pend_nxt   = 1'b0;
        end
        if (tick) begin                                         // see [R3]
          scl_oe_nxt = 1'b0;
          st_nxt     = ibt_pkg::ST_BIT_HIGH;
        end
      end
      ibt_pkg::ST_BIT_HIGH: begin
        if (tick) begin                                         // see [R4]
          scl_oe_nxt = 1'b1;
          shreg_nxt  = {shreg_r[6:0], 1'b0};                    // see [R17]
          bitcnt_nxt = bitcnt_r + 1'b1;
          pend_nxt   = 1'b1;
          if (bitcnt_r == ibt_pkg::BITCNT_LAST) begin
            st_nxt = ibt_pkg::ST_ACK_LOW;                       // see [R8]
          end else begin
            st_nxt = ibt_pkg::ST_BIT_LOW;
          end
        end
      end
      ibt_pkg::ST_ACK_LOW: begin
        if (pend_r) begin
          sda_oe_nxt                 = 1'b0;                    // see [R5]
          dn_nxt[ibt_pkg::DN_BF_CLR] = 1'b1;
          pend_nxt                   = 1'b0;
        end
        if (tick) begin
          scl_oe_nxt = 1'b0;
          st_nxt     = ibt_pkg::ST_ACK_HIGH;
        end
      end
      ibt_pkg::ST_ACK_HIGH: begin
        if (tick) begin
          lack_nxt                 = sda_s2_r;                  // see [R6]
          scl_oe_nxt               = 1'b1;                      // see [R9]
          dn_nxt[ibt_pkg::DN_BYTE] = 1'b1;                      // see [R7]
          st_nxt                   = ibt_pkg::ST_IDLE;
        end
      end
      ibt_pkg::ST_STOP_A: begin
        if (tick) begin
          scl_oe_nxt = 1'b0;
          st_nxt     = ibt_pkg::ST_STOP_B;
        end
      end
      ibt_pkg::ST_STOP_B: begin
        if (tick) begin
          sda_oe_nxt = 1'b0;
          st_nxt     = ibt_pkg::ST_STOP_C;
        end
      end
      ibt_pkg::ST_STOP_C: begin
        if (tick) begin
          dn_nxt[ibt_pkg::DN_STOP] = 1'b1;                      // see [R15]
          st_nxt                   = ibt_pkg::ST_IDLE;
        end
      end
      ibt_pkg::ST_RS_A: begin
        if (tick) begin
          scl_oe_nxt = 1'b0;
          st_nxt     = ibt_pkg::ST_RS_B;
        end
      end
      ibt_pkg::ST_RS_B: begin
        if (tick) begin
          sda_oe_nxt = 1'b1;
          st_nxt     = ibt_pkg::ST_START_A;
        end
      end
      default: begin
        st_nxt = ibt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n_r) begin
      st_r       <= ibt_pkg::ST_IDLE;
      cnt_r      <= '0;
      shreg_r    <= ibt_pkg::TXBUF_RST;
      bitcnt_r   <= ibt_pkg::BITCNT_RST;
      pend_r     <= 1'b0;
      scl_oe_r   <= 1'b0;
      sda_oe_r   <= 1'b0;
      lack_r     <= 1'b0;
      rs_r       <= 1'b0;
      dn_r       <= '0;
      drive_lo_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      shreg_r    <= shreg_nxt;
      bitcnt_r   <= bitcnt_nxt;
      pend_r     <= pend_nxt;
      scl_oe_r   <= scl_oe_nxt;
      sda_oe_r   <= sda_oe_nxt;
      lack_r     <= lack_nxt;
      rs_r       <= rs_nxt;
      dn_r       <= dn_nxt;
      drive_lo_r <= 1'b0;
    end
  end

  assign BUFFER_FULL_FLAG           = bf_r;
  assign PORT_IRQ_FLAG              = irq_r;
  assign ACK_RECEIVED_STATUS        = ack_r;
  assign WRITE_COLLISION_FLAG       = write_collision_flag_r;
  assign START_REQUEST_BIT          = sen_r;
  assign STOP_REQUEST_BIT           = pen_r;
  assign REPEATED_START_REQUEST_BIT = repeated_start_request_bit_r;
  assign BUSY                       = busy_r;
  // open drain: the pads only ever pull low
  assign SDA_O                      = drive_lo_r;
  assign SCL_O                      = drive_lo_r;
  assign SDA_OE                     = sda_oe_r;
  assign SCL_OE                     = scl_oe_r;

endmodule

// ===== ibt_master_tx_assertions.sv
// concurrent checks on the ports of the two-wire master byte transmitter
// assumes bind into ibt_master_tx; RST_N also quiets the link-side checks
`timescale 1ns/1ns
module ibt_master_tx_chk #(
  parameter int BAUD_W = 8
) (
  input wire logic              SYS_CLK,
  input wire logic              RST_N,
  input wire logic              SHIFT_BUFFER_WR,
  input wire logic              WRITE_COLLISION_FLAG_CLR,
  input wire logic [BAUD_W-1:0] BAUD_RELOAD,
  input wire logic              BUFFER_FULL_FLAG,
  input wire logic              PORT_IRQ_FLAG,
  input wire logic              ACK_RECEIVED_STATUS,
  input wire logic              WRITE_COLLISION_FLAG,
  input wire logic              START_REQUEST_BIT,
  input wire logic              STOP_REQUEST_BIT,
  input wire logic              REPEATED_START_REQUEST_BIT,
  input wire logic              BUSY,
  input wire logic              LINK_CLK,
  input wire logic              SDA_OE,
  input wire logic              SCL_OE
);
  logic        scl_q_r;
  logic        scl_q_nxt;
  logic        arm_r;
  logic        arm_nxt;
  logic [15:0] run_r;
  logic [15:0] run_nxt;
  // byte phase only: start, stop and restart move sda under a high clock
  wire         byte_act = BUSY && !START_REQUEST_BIT && !STOP_REQUEST_BIT &&
                          !REPEATED_START_REQUEST_BIT;
  wire         edge_w   = SCL_OE != scl_q_r;
  always_comb begin
    scl_q_nxt = SCL_OE;
    run_nxt   = edge_w ? 16'h0001 : run_r + 16'h0001;
    // first run of a byte carries the idle wait and any start hold, so it is not measured
    arm_nxt   = byte_act && (arm_r || edge_w);
  end
  always_ff @(posedge LINK_CLK) begin
    if (!RST_N) begin
      scl_q_r <= 1'b0;
      run_r   <= 16'h0000;
      arm_r   <= 1'b0;
    end else begin
      scl_q_r <= scl_q_nxt;
      run_r   <= run_nxt;
      arm_r   <= arm_nxt;
    end
  end
  sequence s_wr_free;
    SHIFT_BUFFER_WR && !BUSY;
  endsequence
  sequence s_taken;
    BUFFER_FULL_FLAG && BUSY;
  endsequence
  a_wr_sets_full: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_wr_free |=> s_taken) else $error("write did not set full flag");
  a_wr_collides: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    SHIFT_BUFFER_WR && BUSY |=> WRITE_COLLISION_FLAG) else $error("no collision flag");
  a_write_collision_flag_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    WRITE_COLLISION_FLAG && !WRITE_COLLISION_FLAG_CLR |=> WRITE_COLLISION_FLAG) else $error("collision lost");
  a_full_frees: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $fell(BUFFER_FULL_FLAG) |-> !SDA_OE) else $error("sda held at full clear");
  a_irq_parks: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(PORT_IRQ_FLAG) && !$past(STOP_REQUEST_BIT, 2) |-> SCL_OE ##[0:2] !BUSY)
    else $error("clock not parked low at done");
  a_ack_with_irq: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $changed(ACK_RECEIVED_STATUS) |-> $rose(PORT_IRQ_FLAG)) else $error("ack moved alone");
  a_idle_still: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !BUSY && !$past(BUSY) |-> $stable(SCL_OE) && $stable(SDA_OE)) else $error("bus moved idle");
  a_sda_scl_low: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    byte_act && $changed(SDA_OE) |-> SCL_OE && $past(SCL_OE)) else $error("sda moved, scl high");
  a_phase_len: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    byte_act && edge_w && arm_r |-> run_r == 16'(BAUD_RELOAD) + 16'h0001)
    else $error("scl phase length wrong");
endmodule

bind ibt_master_tx ibt_master_tx_chk #(.BAUD_W(BAUD_W)) ibt_master_tx_chk_inst (
  .SYS_CLK, .RST_N, .SHIFT_BUFFER_WR, .WRITE_COLLISION_FLAG_CLR, .BAUD_RELOAD, .BUFFER_FULL_FLAG,
  .PORT_IRQ_FLAG, .ACK_RECEIVED_STATUS, .WRITE_COLLISION_FLAG, .START_REQUEST_BIT,
  .STOP_REQUEST_BIT, .REPEATED_START_REQUEST_BIT, .BUSY, .LINK_CLK, .SDA_OE, .SCL_OE);

// ===== ibt_pkg.sv
// shared constants and types for the two-wire master byte transmitter
// assumes the bench and design import nothing; names are used with ibt_pkg::
package ibt_pkg;

  localparam int          BYTE_BITS      = 8;
  localparam int          BAUD_W_DEF     = 8;
  localparam logic [7:0]  BAUD_RELOAD_RST = 8'h04;

  // index of each event sent from the system side to the link side
  localparam int          GO_BYTE        = 0;
  localparam int          GO_START       = 1;
  localparam int          GO_STOP        = 2;
  localparam int          GO_RSTART      = 3;
  localparam int          GO_W           = 4;

  // index of each event sent from the link side to the system side
  localparam int          DN_BF_CLR      = 0;
  localparam int          DN_BYTE        = 1;
  localparam int          DN_START       = 2;
  localparam int          DN_STOP        = 3;
  localparam int          DN_RSTART      = 4;
  localparam int          DN_W           = 5;

  localparam logic [7:0]  TXBUF_RST      = 8'h00;
  localparam logic [3:0]  BITCNT_RST     = 4'h0;
  localparam logic [3:0]  BITCNT_LAST    = 4'h7;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START_A,
    ST_START_B,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_ACK_LOW,
    ST_ACK_HIGH,
    ST_STOP_A,
    ST_STOP_B,
    ST_STOP_C,
    ST_RS_A,
    ST_RS_B
  } ibt_state_e;

endpackage

// ===== ibt_slave_model.sv
// behavioural two-wire slave: acks its address, general call and data bytes
// assumes resolved pull-up wires; sda_oe high pulls sda low
`timescale 1ns/1ns
module ibt_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  output logic [7:0]      last_byte,
  output int              stop_cnt
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       first = 1'b0;
  logic [7:0] sh    = 8'h00;
  int         cnt   = 0;
  initial begin
    sda_oe    = 1'b0;
    last_byte = 8'h00;
    stop_cnt  = 0;
  end
  always @(scl or sda) begin
    if (scl && scl_q && sda !== sda_q) begin
      // sda moving under a high clock frames a transfer
      cnt   = 0;
      first = !sda;
      if (sda) stop_cnt++;
    end else if (scl && !scl_q) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      cnt++;
    end else if (!scl && scl_q && cnt == 8) begin
      last_byte = sh;
      sda_oe    = !first || sh[7:1] == ADDR || sh[7:1] == 7'h00;
      first     = 1'b0;
    end else if (!scl && scl_q && cnt == 9) begin
      // no hold beyond the ninth fall: no kinder than a fast slave
      sda_oe = 1'b0;
      cnt    = 0;
    end
    scl_q = scl;
    sda_q = sda;
  end
endmodule

// ===== test_ibt_master_tx.sv
// bench: start, address and data bytes, a collision, restart, nack and stop
// assumes ibt_pkg is compiled first; the slave model stands on the bus
`timescale 1ns/1ns
module test_ibt_master_tx;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [3:0] WR   = 4'h1;
  localparam logic [3:0] ST   = 4'h2;
  localparam logic [3:0] SP   = 4'h4;
  localparam logic [3:0] RS   = 4'h8;
  logic       sys_clk  = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_n    = 1'b0;
  logic [3:0] req_v    = 4'h0;
  logic [1:0] clr_v    = 2'h0;
  logic [7:0] data     = 8'h00;
  logic [7:0] reload   = 8'h02;
  logic       bf, irq, ack, write_collision_flag, srb, prb, rrb, busy, sda_o, sda_oe, scl_o, scl_oe, s_oe;
  logic [7:0] last_byte;
  int         stop_cnt;
  int         mismatches  = 0;
  int         checks_done = 0;
  wire        sda_w = !(sda_oe || s_oe);
  wire        scl_w = !scl_oe;
  initial forever #25 sys_clk = ~sys_clk;
  // phase offset keeps the two clocks unrelated
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  ibt_master_tx #(.BAUD_W(8)) ibt_master_tx_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .SHIFT_BUFFER_WR(req_v[0]), .SHIFT_BUFFER_DATA(data),
    .START_REQ(req_v[1]), .STOP_REQ(req_v[2]), .RSTART_REQ(req_v[3]), .IRQ_CLR(clr_v[0]),
    .WRITE_COLLISION_FLAG_CLR(clr_v[1]), .BAUD_RELOAD(reload), .BUFFER_FULL_FLAG(bf), .PORT_IRQ_FLAG(irq),
    .ACK_RECEIVED_STATUS(ack), .WRITE_COLLISION_FLAG(write_collision_flag), .START_REQUEST_BIT(srb),
    .STOP_REQUEST_BIT(prb), .REPEATED_START_REQUEST_BIT(rrb), .BUSY(busy),
    .LINK_CLK(link_clk), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe), .SCL_O(scl_o),
    .SCL_OE(scl_oe));
  ibt_slave_model #(.ADDR(ADDR)) ibt_slave_model_inst (
    .scl(scl_w), .sda(sda_w), .sda_oe(s_oe), .last_byte(last_byte), .stop_cnt(stop_cnt));
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe cycle, then a cycle for the registered flags to land
  task automatic drv(input logic [3:0] r, input logic [1:0] m, input logic [7:0] d);
    @(negedge sys_clk);
    req_v = r;
    clr_v = m;
    data  = d;
    @(negedge sys_clk);
    req_v = 4'h0;
    clr_v = 2'h0;
    @(negedge sys_clk);
  endtask
  task automatic wait_irq;
    int n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk1(irq, 1'b1);
  endtask
  task automatic t_start;
    drv(ST, 2'h0, 8'h00);
    chk1(srb && busy, 1'b1);
    wait_irq();
    chk1(srb, 1'b0);
    chk1(scl_w || sda_w, 1'b0);
    drv(4'h0, 2'h1, 8'h00);
    chk1(irq, 1'b0);
  endtask
  task automatic t_byte(input logic [7:0] d, input logic a);
    drv(WR, 2'h0, d);
    chk1(bf && busy, 1'b1);
    wait_irq();
    chk1(bf || busy, 1'b0);
    chk8(last_byte, d);
    chk1(ack, !a);
    chk1(scl_w || sda_oe, 1'b0);
    drv(4'h0, 2'h1, 8'h00);
  endtask
  task automatic t_coll(input logic [7:0] d);
    drv(WR, 2'h0, d);
    drv(WR, 2'h0, ~d);
    chk1(write_collision_flag, 1'b1);
    drv(ST, 2'h0, 8'h00);
    chk1(srb, 1'b0);
    wait_irq();
    chk8(last_byte, d);
    drv(4'h0, 2'h1, 8'h00);
    chk1(write_collision_flag, 1'b1);
    drv(4'h0, 2'h2, 8'h00);
    chk1(write_collision_flag, 1'b0);
  endtask
  task automatic t_end(input logic s);
    int c;
    c = stop_cnt;
    drv(s ? SP : RS, 2'h0, 8'h00);
    chk1(s ? prb : rrb, 1'b1);
    wait_irq();
    chk1(scl_w, s);
    chk1(sda_w, s);
    chk8(8'(stop_cnt - c), {7'h00, s});
    drv(4'h0, 2'h1, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk8({bf, irq, ack, write_collision_flag, srb, prb, rrb, busy}, 8'h00);
    chk1(sda_oe || scl_oe || sda_o || scl_o, 1'b0);
    for (int i = 2; i < 4; i++) begin
      reload = 8'(i);
      t_start();
      t_byte({ADDR, 1'b0}, 1'b1);
      t_byte(8'hA5, 1'b1);
      t_coll(8'h3C);
      t_end(1'b0);
      t_byte({7'h15, 1'b1}, 1'b0);
      t_end(1'b1);
    end
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
endmodule
